/* hw/bbl_exec_consts.svh */
/*
  Constants of the byte, bit and literal executor: encodings, register
  offsets and reset values. Assumes inclusion by bare name, no other needs.
*/
`ifndef BBL_EXEC_CONSTS_SVH
`define BBL_EXEC_CONSTS_SVH

// Instruction groups in word bits 13:12
`define BBL_GRP_BYTE     2'h0
`define BBL_GRP_BIT      2'h1
`define BBL_GRP_LIT      2'h3
// Byte group opcodes in bits 11:8
`define BBL_OPC_STORE    4'h0
`define BBL_OPC_OR       4'h4
`define BBL_OPC_AND      4'h5
`define BBL_OPC_ADD      4'h7
`define BBL_OPC_COPY     4'h8
`define BBL_OPC_SWAP     4'he
// Bit group opcodes in bits 11:10
`define BBL_OPB_CLEAR    2'h0
`define BBL_OPB_SET      2'h1
`define BBL_OPB_TEST     2'h2
// Literal group opcodes
`define BBL_OPL_LOAD     2'h0
`define BBL_OPL_AND      4'h9
`define BBL_OPL_XOR      4'ha
`define BBL_OPL_ADD      3'h7
// Register port offsets
`define BBL_OFS_FILE_TOP 8'h7f
`define BBL_OFS_ACC      8'h80
`define BBL_OFS_STATUS   8'h81
// Reset values
`define BBL_RST_BYTE     8'h00
`define BBL_RST_FLAGS    3'h0

`endif

/* hw/bbl_pkg.sv */
/*
  Types of the byte, bit and literal executor: decoded operations,
  sequencing states, register port targets and carriers.
  Assumes nothing of its surroundings.
*/
package bbl_pkg;

  typedef enum logic [3:0] {
    BBL_OP_NONE, BBL_OP_ADD_F, BBL_OP_AND_F, BBL_OP_OR_F, BBL_OP_COPY_F,
    BBL_OP_SWAP_F, BBL_OP_STORE_F, BBL_OP_CLR_B, BBL_OP_SET_B, BBL_OP_TEST_B,
    BBL_OP_LOAD_L, BBL_OP_XOR_L, BBL_OP_ADD_L, BBL_OP_AND_L
  } bbl_op_t;

  typedef enum logic {BBL_RUN, BBL_FLUSH} bbl_state_t;

  typedef enum logic [1:0] {BBL_T_FILE, BBL_T_ACC, BBL_T_STATUS, BBL_T_NONE} bbl_target_t;

  // Status flags: zero, digit carry, carry
  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } bbl_flags_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bbl_bus_req_t;

endpackage

/* hw/bbl_exec.sv */
/*
  Decode and execute logic for the byte, bit and literal instructions of a
  small 8-bit core: accumulator, status flags and file register storage.
  Assumes one instruction word per cycle with instr_valid, synchronous to
  sys_clk, and a register port master that never asserts both strobes.
*/
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
`include "bbl_exec_consts.svh"
`default_nettype none

module bbl_exec #(
  parameter int FILE_DEPTH = 128
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // Instruction words from program memory
  input  wire logic                 instr_valid,
  input  wire logic [13:0]          instr_word,
  // Register port
  input  wire bbl_pkg::bbl_bus_req_t bus_req,
  output logic      [7:0]           bus_rdata,
  // Core state and events
  output logic      [7:0]           acc_out,
  output var bbl_pkg::bbl_flags_t   flags_out,
  output logic                      retire_pulse,
  output logic                      discard_pulse,
  output logic                      unsupported_pulse
);

  // Depth check: the 7-bit address reaches at most 128 entries
  if (FILE_DEPTH < 1 || FILE_DEPTH > 128)
  begin : g_depth_check
    $error("FILE_DEPTH must lie between 1 and 128");
  end

  bbl_pkg::bbl_state_t state_reg;
  bbl_pkg::bbl_op_t    op;
  logic [7:0]          file_mem [FILE_DEPTH];
  logic [6:0]          f_addr;
  logic [2:0]          bsel;
  logic [7:0]          lit;
  logic [7:0]          f_val;
  logic [7:0]          opnd;
  logic [8:0]          sum9;
  logic [4:0]          sum5;
  logic [7:0]          result;
  logic                to_file;
  logic                wr_acc;
  logic                wr_file;
  logic                upd_z;
  logic                upd_cdc;
  logic                exec_en;
  logic                skip_taken;
  bbl_pkg::bbl_target_t wr_tgt;
  bbl_pkg::bbl_target_t rd_tgt;

  // Instruction word to operation
  function automatic bbl_pkg::bbl_op_t decode(input logic [13:0] w);
    bbl_pkg::bbl_op_t o;
    o = bbl_pkg::BBL_OP_NONE;
    case (w[13:12])
      `BBL_GRP_BYTE:
        case (w[11:8])
          `BBL_OPC_STORE: o = w[7] ? bbl_pkg::BBL_OP_STORE_F : bbl_pkg::BBL_OP_NONE;
          `BBL_OPC_OR:    o = bbl_pkg::BBL_OP_OR_F;
          `BBL_OPC_AND:   o = bbl_pkg::BBL_OP_AND_F;
          `BBL_OPC_ADD:   o = bbl_pkg::BBL_OP_ADD_F;
          `BBL_OPC_COPY:  o = bbl_pkg::BBL_OP_COPY_F;
          `BBL_OPC_SWAP:  o = bbl_pkg::BBL_OP_SWAP_F;
          default:        o = bbl_pkg::BBL_OP_NONE;
        endcase
      `BBL_GRP_BIT:
        case (w[11:10])
          `BBL_OPB_CLEAR: o = bbl_pkg::BBL_OP_CLR_B;
          `BBL_OPB_SET:   o = bbl_pkg::BBL_OP_SET_B;
          `BBL_OPB_TEST:  o = bbl_pkg::BBL_OP_TEST_B;
          default:        o = bbl_pkg::BBL_OP_NONE;
        endcase
      `BBL_GRP_LIT:
        if (w[11:10] == `BBL_OPL_LOAD)
          o = bbl_pkg::BBL_OP_LOAD_L;
        else if (w[11:9] == `BBL_OPL_ADD)
          o = bbl_pkg::BBL_OP_ADD_L;
        else if (w[11:8] == `BBL_OPL_AND)
          o = bbl_pkg::BBL_OP_AND_L;
        else if (w[11:8] == `BBL_OPL_XOR)
          o = bbl_pkg::BBL_OP_XOR_L;
        else
          o = bbl_pkg::BBL_OP_NONE;
      default: o = bbl_pkg::BBL_OP_NONE;
    endcase
    return o;
  endfunction

  // Register port address to target, used for reads and writes
  function automatic bbl_pkg::bbl_target_t target(input logic [7:0] a);
    bbl_pkg::bbl_target_t t;
    if (a <= `BBL_OFS_FILE_TOP && 32'(a) < FILE_DEPTH)
      t = bbl_pkg::BBL_T_FILE;
    else if (a == `BBL_OFS_ACC)
      t = bbl_pkg::BBL_T_ACC;
    else if (a == `BBL_OFS_STATUS)
      t = bbl_pkg::BBL_T_STATUS;
    else
      t = bbl_pkg::BBL_T_NONE;
    return t;
  endfunction

  // Operand fields and file read
  assign op      = decode(instr_word);
  assign f_addr  = instr_word[6:0];
  assign to_file = instr_word[7];
  assign bsel    = instr_word[9:7];
  assign lit     = instr_word[7:0];
  assign f_val   = (32'(f_addr) < FILE_DEPTH) ? file_mem[f_addr] : `BBL_RST_BYTE;
  assign exec_en = instr_valid && (state_reg == bbl_pkg::BBL_RUN);
  assign wr_tgt  = target(bus_req.addr);
  assign rd_tgt  = target(bus_req.addr);

  // Adder shared by both add forms
  assign opnd = (op == bbl_pkg::BBL_OP_ADD_L) ? lit : f_val;
  assign sum9 = {1'b0, acc_out} + {1'b0, opnd};
  assign sum5 = {1'b0, acc_out[3:0]} + {1'b0, opnd[3:0]};
  assign skip_taken = (op == bbl_pkg::BBL_OP_TEST_B) && !f_val[bsel];

  // Result and write selection
  always_comb
  begin
    result  = `BBL_RST_BYTE;
    wr_acc  = 1'b0;
    wr_file = 1'b0;
    upd_z   = 1'b0;
    upd_cdc = 1'b0;
    case (op)
      bbl_pkg::BBL_OP_ADD_F:
      begin
        result  = sum9[7:0];
        upd_z   = 1'b1;
        upd_cdc = 1'b1;
        wr_acc  = !to_file;
        wr_file = to_file;
      end
      bbl_pkg::BBL_OP_AND_F:
      begin
        result  = acc_out & f_val;
        upd_z   = 1'b1;
        wr_acc  = !to_file;
        wr_file = to_file;
      end
      bbl_pkg::BBL_OP_OR_F:
      begin
        result  = acc_out | f_val;
        upd_z   = 1'b1;
        wr_acc  = !to_file;
        wr_file = to_file;
      end
      bbl_pkg::BBL_OP_COPY_F:
      begin
        result  = f_val;
        upd_z   = 1'b1;
        wr_acc  = !to_file;
        wr_file = to_file;
      end
      bbl_pkg::BBL_OP_SWAP_F:
      begin
        result  = {f_val[3:0], f_val[7:4]};
        wr_acc  = !to_file;
        wr_file = to_file;
      end
      bbl_pkg::BBL_OP_STORE_F:
      begin
        result  = acc_out;
        wr_file = 1'b1;
      end
      bbl_pkg::BBL_OP_CLR_B:
      begin
        result  = f_val & ~(8'h01 << bsel);
        wr_file = 1'b1;
      end
      bbl_pkg::BBL_OP_SET_B:
      begin
        result  = f_val | (8'h01 << bsel);
        wr_file = 1'b1;
      end
      bbl_pkg::BBL_OP_LOAD_L:
      begin
        result  = lit;
        wr_acc  = 1'b1;
      end
      bbl_pkg::BBL_OP_XOR_L:
      begin
        result  = acc_out ^ lit;
        upd_z   = 1'b1;
        wr_acc  = 1'b1;
      end
      bbl_pkg::BBL_OP_ADD_L:
      begin
        result  = sum9[7:0];
        upd_z   = 1'b1;
        upd_cdc = 1'b1;
        wr_acc  = 1'b1;
      end
      bbl_pkg::BBL_OP_AND_L:
      begin
        result  = acc_out & lit;
        upd_z   = 1'b1;
        wr_acc  = 1'b1;
      end
      default:
      begin
        result  = `BBL_RST_BYTE;
      end
    endcase
  end

  // File storage, one byte per generate step; execution beats the port
  for (genvar i = 0; i < FILE_DEPTH; i++)
  begin : g_file
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
        file_mem[i] <= `BBL_RST_BYTE;
      else if (exec_en && wr_file && 32'(f_addr) == i)
        file_mem[i] <= result;
      else if (bus_req.wr && wr_tgt == bbl_pkg::BBL_T_FILE && 32'(bus_req.addr) == i)
        file_mem[i] <= bus_req.wdata;
    end
  end

  // Accumulator
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      acc_out <= `BBL_RST_BYTE;
    else if (exec_en && wr_acc)
      acc_out <= result;
    else if (bus_req.wr && wr_tgt == bbl_pkg::BBL_T_ACC)
      acc_out <= bus_req.wdata;
  end

  // Status flags
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_out <= `BBL_RST_FLAGS;
    else if (exec_en && (upd_z || upd_cdc))
    begin
      flags_out.z <= (result == 8'h00);
      if (upd_cdc)
      begin
        flags_out.c  <= sum9[8];
        flags_out.dc <= sum5[4];
      end
    end
    else if (bus_req.wr && wr_tgt == bbl_pkg::BBL_T_STATUS)
      flags_out <= bus_req.wdata[2:0];
  end

  // Skip sequencing: a taken test discards the next word
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= bbl_pkg::BBL_RUN;
    else
      case (state_reg)
        bbl_pkg::BBL_RUN:
          if (exec_en && skip_taken)
            state_reg <= bbl_pkg::BBL_FLUSH;
        bbl_pkg::BBL_FLUSH:
          if (instr_valid)
            state_reg <= bbl_pkg::BBL_RUN;
        default:
          state_reg <= bbl_pkg::BBL_RUN;
      endcase
  end

  // Event pulses, one cycle after the word
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      retire_pulse      <= 1'b0;
      discard_pulse     <= 1'b0;
      unsupported_pulse <= 1'b0;
    end
    else
    begin
      retire_pulse      <= exec_en && op != bbl_pkg::BBL_OP_NONE;
      discard_pulse     <= instr_valid && state_reg == bbl_pkg::BBL_FLUSH;
      unsupported_pulse <= exec_en && op == bbl_pkg::BBL_OP_NONE;
    end
  end

  // Register port read data, valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      bus_rdata <= `BBL_RST_BYTE;
    else if (!bus_req.rd)
      bus_rdata <= `BBL_RST_BYTE;
    else
      case (rd_tgt)
        bbl_pkg::BBL_T_FILE:   bus_rdata <= file_mem[bus_req.addr[6:0]];
        bbl_pkg::BBL_T_ACC:    bus_rdata <= acc_out;
        bbl_pkg::BBL_T_STATUS: bus_rdata <= {5'h00, flags_out};
        default:               bus_rdata <= `BBL_RST_BYTE;
      endcase
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_skip_taken;
    exec_en && skip_taken;
  endsequence

  sequence s_discarded;
    instr_valid && !bus_req.wr ##1 (discard_pulse && !retire_pulse);
  endsequence

  a_add_file_sum: assert property (
    exec_en && op == bbl_pkg::BBL_OP_ADD_F && !to_file && !bus_req.wr
    |=> {flags_out.c, acc_out} == $past(sum9) && flags_out.dc == $past(sum5[4]))
    else $error("file add sum or carry wrong");
  a_and_file_zero: assert property (
    exec_en && op == bbl_pkg::BBL_OP_AND_F && !to_file
    |=> acc_out == ($past(acc_out) & $past(f_val)) && flags_out.c == $past(flags_out.c)
        && flags_out.z == (acc_out == 8'h00))
    else $error("file and result or flags wrong");
  a_or_file_flags: assert property (
    exec_en && op == bbl_pkg::BBL_OP_OR_F
    |=> flags_out.z == (($past(acc_out) | $past(f_val)) == 8'h00)
        && flags_out.dc == $past(flags_out.dc))
    else $error("file or flags wrong");
  a_copy_zero_test: assert property (
    exec_en && op == bbl_pkg::BBL_OP_COPY_F |=> flags_out.z == ($past(f_val) == 8'h00))
    else $error("copy zero flag wrong");
  a_swap_nibbles: assert property (
    exec_en && op == bbl_pkg::BBL_OP_SWAP_F && !to_file && !bus_req.wr
    |=> acc_out == {$past(f_val[3:0]), $past(f_val[7:4])} && flags_out == $past(flags_out))
    else $error("nibble exchange wrong");
  a_skip_discard: assert property (
    s_skip_taken ##1 s_discarded |-> acc_out == $past(acc_out, 1)
        && flags_out == $past(flags_out, 1))
    else $error("skipped word not discarded");
  a_skip_state: assert property (
    s_skip_taken |=> state_reg == bbl_pkg::BBL_FLUSH && !discard_pulse)
    else $error("taken skip did not arm discard");
  a_load_literal: assert property (
    exec_en && op == bbl_pkg::BBL_OP_LOAD_L && !bus_req.wr
    |=> acc_out == $past(instr_word[7:0]) && flags_out == $past(flags_out))
    else $error("literal load wrong");
  a_xor_literal: assert property (
    exec_en && op == bbl_pkg::BBL_OP_XOR_L
    |=> acc_out == ($past(acc_out) ^ $past(instr_word[7:0])))
    else $error("literal xor wrong");
  a_add_literal: assert property (
    exec_en && op == bbl_pkg::BBL_OP_ADD_L |=> {flags_out.c, acc_out} == $past(sum9))
    else $error("literal add wrong");
  a_single_cycle: assert property (
    exec_en && op != bbl_pkg::BBL_OP_NONE |=> retire_pulse && !discard_pulse)
    else $error("instruction did not retire in one cycle");
  a_bit_write: assert property (
    exec_en && (op == bbl_pkg::BBL_OP_CLR_B || op == bbl_pkg::BBL_OP_SET_B) && !bus_req.wr
    |=> file_mem[$past(f_addr)][$past(bsel)] == $past(op == bbl_pkg::BBL_OP_SET_B)
        && flags_out == $past(flags_out))
    else $error("bit clear or set wrong");
  a_store_acc: assert property (
    exec_en && op == bbl_pkg::BBL_OP_STORE_F && !bus_req.wr
    |=> file_mem[$past(f_addr)] == $past(acc_out) && flags_out == $past(flags_out))
    else $error("accumulator store wrong");

endmodule

`default_nettype wire

/* hw/bbl_exec_unused_guard.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* dv/bbl_prog_mem.sv */
/*
  Program memory model: plays a stored word list to the executor.
  Assumes the bench loads mem and pulses go for one cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module bbl_prog_mem (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Control from the bench
  input  wire logic        go,
  input  wire logic [3:0]  len,
  // Instruction words
  output logic             instr_valid,
  output logic [13:0]      instr_word,
  output logic             busy
);
  logic [13:0] mem [0:15];
  logic [3:0]  ptr;

  // One word per cycle; idle bus toggles so stale words never look valid
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      instr_valid <= 1'b0;
      instr_word  <= 14'h0000;
      busy        <= 1'b0;
      ptr         <= 4'h0;
    end
    else if (go)
    begin
      busy <= 1'b1;
      ptr  <= 4'h0;
    end
    else if (busy && ptr != len)
    begin
      instr_valid <= 1'b1;
      instr_word  <= mem[ptr];
      ptr         <= ptr + 4'h1;
    end
    else
    begin
      busy        <= 1'b0;
      instr_valid <= 1'b0;
      instr_word  <= ~instr_word;
    end
  end
endmodule

`default_nettype wire

/* dv/testbench.sv */
/*
  Self-checking bench of the byte, bit and literal executor.
  Assumes the program memory model and the register port master below.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic                  sys_clk, reset_n, go, busy;
  logic [3:0]            len;
  logic                  instr_valid;
  logic [13:0]           instr_word;
  bbl_pkg::bbl_bus_req_t bus_req;
  logic [7:0]            bus_rdata, acc_out;
  bbl_pkg::bbl_flags_t   flags_out;
  logic                  retire_pulse, discard_pulse, unsupported_pulse;
  int                    bad_count = 0, n_checks = 0, cyc = 0;
  int                    n_ret = 0, n_disc = 0, n_uns = 0;

  bbl_exec i_bbl_exec (.sys_clk(sys_clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .bus_req(bus_req), .bus_rdata(bus_rdata), .acc_out(acc_out),
    .flags_out(flags_out), .retire_pulse(retire_pulse), .discard_pulse(discard_pulse),
    .unsupported_pulse(unsupported_pulse));

  bbl_prog_mem i_bbl_prog_mem (.sys_clk(sys_clk), .reset_n(reset_n), .go(go), .len(len),
    .instr_valid(instr_valid), .instr_word(instr_word), .busy(busy));

  // Clock and event counters, hang guard
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (retire_pulse === 1'b1) n_ret = n_ret + 1;
    if (discard_pulse === 1'b1) n_disc = n_disc + 1;
    if (unsupported_pulse === 1'b1) n_uns = n_uns + 1;
    if (cyc == 5000)
    begin
      bad_count = bad_count + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register port master
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    chk("bus_rdata", {8'h00, bus_rdata}, {8'h00, exp});
    @(posedge sys_clk);
    #1;
    chk("bus_rdata_idle", {8'h00, bus_rdata}, 16'h0000);
  endtask

  // Play n stored words back to back, then let answers land
  task automatic run(input logic [3:0] n);
    @(posedge sys_clk);
    len <= n;
    go  <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (2) @(posedge sys_clk);
    while (busy) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic exec1(input logic [13:0] w);
    int r0;
    r0 = n_ret;
    i_bbl_prog_mem.mem[0] = w;
    run(4'h1);
    chk("retire_count", 16'(n_ret - r0), 16'h0001);
  endtask

  task automatic chk_af(input logic [7:0] a, input logic [2:0] f);
    chk("acc_flags", {acc_out, 5'h00, flags_out}, {a, 5'h00, f});
  endtask

  // Reset values, port map, unmapped place, refused word
  task automatic t_regs();
    int u0;
    bus_rd(8'h80, 8'h00);
    bus_rd(8'h81, 8'h00);
    bus_wr(8'h90, 8'h55);
    bus_rd(8'h90, 8'h00);
    bus_wr(8'h80, 8'h3c);
    bus_wr(8'h81, 8'h07);
    bus_rd(8'h81, 8'h07);
    u0 = n_uns;
    i_bbl_prog_mem.mem[0] = 14'h2000;
    run(4'h1);
    chk("unsupported", 16'(n_uns - u0), 16'h0001);
    chk_af(8'h3c, 3'h7);
    $display("test regs done");
  endtask

  // Literal group
  task automatic t_lit();
    exec1(14'h3010);
    exec1(14'h3e15);
    chk_af(8'h25, 3'h0);
    exec1(14'h30a3);
    exec1(14'h395f);
    chk_af(8'h03, 3'h0);
    exec1(14'h30b5);
    exec1(14'h3aaf);
    chk_af(8'h1a, 3'h0);
    exec1(14'h30ff);
    exec1(14'h3e01);
    chk_af(8'h00, 3'h7);
    exec1(14'h305a);
    chk_af(8'h5a, 3'h7);
    $display("test literal done");
  endtask

  // Byte and bit groups on the file
  task automatic t_file();
    bus_wr(8'h20, 8'hc2);
    exec1(14'h3017);
    exec1(14'h0720);
    chk_af(8'hd9, 3'h0);
    exec1(14'h3017);
    exec1(14'h05a0);
    chk_af(8'h17, 3'h0);
    bus_rd(8'h20, 8'h02);
    bus_wr(8'h21, 8'h13);
    exec1(14'h3091);
    exec1(14'h0421);
    chk_af(8'h93, 3'h0);
    exec1(14'h08a2);
    chk_af(8'h93, 3'h4);
    exec1(14'h0e21);
    chk_af(8'h31, 3'h4);
    exec1(14'h00a3);
    bus_rd(8'h23, 8'h31);
    bus_wr(8'h24, 8'hc7);
    exec1(14'h13a4);
    bus_rd(8'h24, 8'h47);
    exec1(14'h15a4);
    chk_af(8'h31, 3'h4);
    bus_rd(8'h24, 8'h4f);
    exec1(14'h0524);
    chk_af(8'h01, 3'h0);
    exec1(14'h07a4);
    chk_af(8'h01, 3'h2);
    bus_rd(8'h24, 8'h50);
    exec1(14'h0ea4);
    bus_rd(8'h24, 8'h05);
    exec1(14'h0824);
    chk_af(8'h05, 3'h2);
    exec1(14'h04a3);
    bus_rd(8'h23, 8'h35);
    $display("test file done");
  endtask

  // Bit test skip: taken then not taken, back to back words
  task automatic t_skip();
    int r0;
    int d0;
    exec1(14'h30ff);
    exec1(14'h3e01);
    i_bbl_prog_mem.mem[0] = 14'h18a5;
    i_bbl_prog_mem.mem[1] = 14'h3077;
    i_bbl_prog_mem.mem[2] = 14'h30ff;
    r0 = n_ret;
    d0 = n_disc;
    run(4'h3);
    chk_af(8'hff, 3'h7);
    chk("discards", 16'(n_disc - d0), 16'h0001);
    chk("retires", 16'(n_ret - r0), 16'h0002);
    bus_wr(8'h25, 8'h02);
    i_bbl_prog_mem.mem[2] = 14'h3033;
    r0 = n_ret;
    d0 = n_disc;
    run(4'h3);
    chk_af(8'h33, 3'h7);
    chk("discards", 16'(n_disc - d0), 16'h0000);
    chk("retires", 16'(n_ret - r0), 16'h0003);
    $display("test skip done");
  endtask

  initial
  begin
    reset_n = 1'b0;
    go      = 1'b0;
    len     = 4'h0;
    bus_req = '0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs();
    t_lit();
    t_file();
    t_skip();
    end_sim();
  end
endmodule

`default_nettype wire
